// File: hdl/pgrm_pkg.sv
// Behaviour
// - status bit 7 is high when monitor-3 measurement exceeded its high threshold.
// - status bit 6 is high when monitor-3 measurement fell below its low threshold.
// - status bit 5 is high when monitor-4 measurement exceeded its high threshold.
// - status bit 4 flags monitor-4 below low threshold; bits 3:0 read zero.
// - lower bytes 76h to 7Ah are reserved; reads zero, writes ignored.
// - password entry bytes 7Bh-7Eh are writable by anyone and always read zero.
// - password entry resets to all ones.
// - two passwords; higher level includes every privilege of the lower level.
// - both stored passwords live in nonvolatile storage inside higher-level memory.
// - table select at 7Fh is read-write for all and pages upper memory.
// - table select resets to 00h and loads the power-on table choice on the first clock after reset.
// - region A 80h-BFh access via higher level or lower level plus grants.
// - region B C0h-F7h uses the same scheme with region B grants.
// - alarm enables F8h-FAh use the same scheme with region C grants.
// - enable byte F8h gates eight environment and monitor alarms to interrupt.
// - enable byte F9h bits 7:4 gate monitor-3/4 alarms; bits 3:0 reserved.
// - enable byte FAh bits 3,1,0 gate bias and power alarms to fault gate.
// - mask bit chooses whether alarm enables appear in table 1 or table 5.
// - alarm enables are shadowed nonvolatile and read 00h after power-on.
// - shadow write disable set means writes update only the volatile copy.
package pgrm_pkg;
   // ************************************************************
   // byte offsets, one byte per aligned 32-bit word
   // ************************************************************
   localparam logic [7:0] PGRM_WARN_B    = 8'h75;
   localparam logic [7:0] PGRM_RSV_LO    = 8'h76;
   localparam logic [7:0] PGRM_RSV_HI    = 8'h7A;
   localparam logic [7:0] PGRM_PWE_FIRST = 8'h7B;
   localparam logic [7:0] PGRM_PWE_LAST  = 8'h7E;
   localparam logic [7:0] PGRM_TBLSEL    = 8'h7F;
   localparam logic [7:0] PGRM_REGA_LO   = 8'h80;
   localparam logic [7:0] PGRM_REGA_HI   = 8'hBF;
   localparam logic [7:0] PGRM_REGB_LO   = 8'hC0;
   localparam logic [7:0] PGRM_REGB_HI   = 8'hF7;
   localparam logic [7:0] PGRM_EN_ENV    = 8'hF8;
   localparam logic [7:0] PGRM_EN_M34    = 8'hF9;
   localparam logic [7:0] PGRM_EN_FG     = 8'hFA;
   localparam logic [7:0] PGRM_TBL_ONE   = 8'h01;
   localparam logic [7:0] PGRM_TBL_FIVE  = 8'h05;
   localparam logic [31:0] PGRM_PWE_RESET = 32'hFFFF_FFFF;
   localparam logic [7:0] PGRM_EN_RESET   = 8'h00;
   localparam logic [7:0] PGRM_M34_MASK   = 8'hF0;
   localparam logic [7:0] PGRM_FG_MASK    = 8'h0B;
   localparam int PGRM_USER_BYTES         = 120;
endpackage : pgrm_pkg

// File: hdl/pgrm_top.sv
`timescale 1ns/100ps
`default_nettype none
module pgrm_top
   import pgrm_pkg::*;
(
   input  wire logic        hclk,            // bus clock
   input  wire logic        hresetn,         // async reset, low
   input  wire logic        hsel,            // slave select
   input  wire logic [31:0] haddr,           // byte address
   input  wire logic [1:0]  htrans,          // transfer type
   input  wire logic        hwrite,          // write when high
   input  wire logic [2:0]  hsize,           // transfer size
   input  wire logic        hready,          // bus ready in
   input  wire logic [31:0] hwdata,          // write data
   output logic      [31:0] hrdata,          // read data
   output logic             hreadyout,       // slave ready
   output logic             hresp,           // always okay
   input  wire logic [3:0]  mon34_warn,      // monitor_channel_three hi/lo, monitor_channel_four hi/lo, from comparators
   input  wire logic [7:0]  env_alarm,       // temp/vcc/mon1/mon2 alarms, hi bit first
   input  wire logic [3:0]  mon34_alarm,     // monitor_channel_three/monitor_channel_four alarms
   input  wire logic        bias_high_alarm, // bias high alarm
   input  wire logic        tx_power_high_alarm, // tx power high
   input  wire logic        tx_power_low_alarm,  // tx power low
   input  wire logic [31:0] lower_pw_value,  // stored lower password
   input  wire logic [31:0] higher_pw_value, // stored higher password
   input  wire logic [7:0]  power_on_table_choice, // table select at power-on
   input  wire logic        mask_in_table5,  // enables live in table 5
   input  wire logic        shadow_write_disable, // hold enable-byte nv commits
   input  wire logic [5:0]  region_grants,   // rw/ro grants for a, b, c
   output logic             lower_privilege_level,  // lower or higher password matched
   output logic             higher_privilege_level, // higher password matched
   output logic             nv_commit,       // pulse: commit byte to nv
   output logic      [7:0]  nv_commit_addr,  // committed byte offset
   output logic      [7:0]  nv_commit_data,  // committed byte value
   output logic      [7:0]  nv_commit_table, // committed table
   output logic             transmit_fault_interrupt, // enabled alarm active
   output logic             fault_gate_signal         // enabled fault alarm active
);
   // ************************************************************
   // input synchronisers: all monitor and config pins are async
   // ************************************************************
   localparam int SW = 4 + 8 + 4 + 3 + 32 + 32 + 8 + 1 + 1 + 6;
   logic [SW-1:0] sync1, sync2;
   logic [SW-1:0] raw_in;
   assign raw_in = {mon34_warn, env_alarm, mon34_alarm, bias_high_alarm,
                    tx_power_high_alarm, tx_power_low_alarm, lower_pw_value,
                    higher_pw_value, power_on_table_choice, mask_in_table5,
                    shadow_write_disable, region_grants};
   // no reset here, so straps are valid the moment reset lifts
   always_ff @(posedge hclk) begin
      sync1 <= raw_in;
      sync2 <= sync1;
   end
   logic [3:0]  s_warn;
   logic [7:0]  s_env;
   logic [3:0]  s_m34;
   logic [2:0]  s_fga;
   logic [31:0] s_pw1, s_pw2;
   logic [7:0]  s_pon;
   logic        s_mask5, s_shadow_write_disable;
   logic [5:0]  s_grant;
   assign {s_warn, s_env, s_m34, s_fga, s_pw1, s_pw2, s_pon, s_mask5, s_shadow_write_disable,
           s_grant} = sync2;

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0]  warn_b, next_warn_b;
   logic [31:0] password_entry, next_pwe;
   logic [7:0]  upper_table_select, next_upper_table_select;
   logic        tbl_loaded, next_tbl_loaded;
   logic [7:0]  en_env, next_en_env;
   logic [7:0]  en_m34, next_en_m34;
   logic [7:0]  en_fg, next_en_fg;
   logic [7:0]  user_mem [PGRM_USER_BYTES];
   logic        mem_we;
   logic [6:0]  mem_idx;
   logic [7:0]  wr_byte;
   // data phase capture
   logic        dp_wr, next_dp_wr;
   logic        dp_rd, next_dp_rd;
   logic [7:0]  dp_addr, next_dp_addr;
   logic [31:0] rdata, next_rdata;
   logic        commit, next_commit;
   logic [7:0]  c_addr, next_c_addr, c_data, next_c_data, c_tbl, next_c_tbl;
   logic        lvl1, lvl2;

   // ************************************************************
   // privilege decode
   // ************************************************************
   assign lvl2 = (password_entry == s_pw2);
   assign lvl1 = lvl2 | (password_entry == s_pw1);
   assign lower_privilege_level  = lvl1;
   assign higher_privilege_level = lvl2;

   // grant order: {a_rw, a_ro, b_rw, b_ro, c_rw, c_ro}
   function automatic logic can_rd(input logic l1, input logic l2,
                                   input logic rw, input logic ro);
      can_rd = l2 | (l1 & (rw | ro));
   endfunction : can_rd
   function automatic logic can_wr(input logic l1, input logic l2,
                                   input logic rw);
      can_wr = l2 | (l1 & rw);
   endfunction : can_wr

   logic in_a, in_b, in_en, tbl_user, tbl_en;
   logic [7:0] a_sel;
   assign a_sel    = haddr[9:2];
   assign tbl_user = (upper_table_select == PGRM_TBL_ONE);
   assign tbl_en   = s_mask5 ? (upper_table_select == PGRM_TBL_FIVE)
                             : (upper_table_select == PGRM_TBL_ONE);

   // ************************************************************
   // bus slave: zero wait states, read data ready in data phase
   // ************************************************************
   logic ap_ok;
   assign ap_ok = hsel & hready & htrans[1];

   always_comb begin
      logic [7:0] a;
      a = dp_addr;
      next_dp_wr   = ap_ok & hwrite;
      next_dp_rd   = ap_ok & ~hwrite;
      next_dp_addr = ap_ok ? a_sel : dp_addr;
      next_rdata   = 32'h0000_0000;
      in_a  = (a_sel >= PGRM_REGA_LO) && (a_sel <= PGRM_REGA_HI) && tbl_user;
      in_b  = (a_sel >= PGRM_REGB_LO) && (a_sel <= PGRM_REGB_HI) && tbl_user;
      in_en = (a_sel >= PGRM_EN_ENV) && (a_sel <= PGRM_EN_FG) && tbl_en;
      if (ap_ok && !hwrite) begin
         // reserved 76h-7Ah and the entry register fall through to zero
         if (a_sel == PGRM_WARN_B)
            next_rdata = {24'h000000, warn_b};
         else if (a_sel == PGRM_TBLSEL)
            next_rdata = {24'h000000, upper_table_select};
         else if (in_a && can_rd(lvl1, lvl2, s_grant[5], s_grant[4]))
            next_rdata = {24'h000000, user_mem[7'(a_sel - PGRM_REGA_LO)]};
         else if (in_b && can_rd(lvl1, lvl2, s_grant[3], s_grant[2]))
            next_rdata = {24'h000000, user_mem[7'(a_sel - PGRM_REGA_LO)]};
         else if (in_en && can_rd(lvl1, lvl2, s_grant[1], s_grant[0])) begin
            case (a_sel)
               PGRM_EN_ENV: next_rdata = {24'h000000, en_env};
               PGRM_EN_M34: next_rdata = {24'h000000, en_m34};
               default:     next_rdata = {24'h000000, en_fg};
            endcase
         end
      end
   end

   // ************************************************************
   // write side, acts in data phase with hwdata
   // ************************************************************
   logic w_a, w_b, w_en;
   always_comb begin
      logic tu, te;
      tu = (upper_table_select == PGRM_TBL_ONE);
      te = s_mask5 ? (upper_table_select == PGRM_TBL_FIVE) : tu;
      wr_byte = hwdata[7:0];
      w_a  = dp_wr && tu && dp_addr >= PGRM_REGA_LO && dp_addr <= PGRM_REGA_HI
             && can_wr(lvl1, lvl2, s_grant[5]);
      w_b  = dp_wr && tu && dp_addr >= PGRM_REGB_LO && dp_addr <= PGRM_REGB_HI
             && can_wr(lvl1, lvl2, s_grant[3]);
      w_en = dp_wr && te && dp_addr >= PGRM_EN_ENV && dp_addr <= PGRM_EN_FG
             && can_wr(lvl1, lvl2, s_grant[1]);
      mem_we  = w_a | w_b;
      mem_idx = 7'(dp_addr - PGRM_REGA_LO);
      next_pwe = password_entry;
      if (dp_wr && dp_addr >= PGRM_PWE_FIRST && dp_addr <= PGRM_PWE_LAST) begin
         case (dp_addr)
            PGRM_PWE_FIRST:        next_pwe[31:24] = wr_byte;
            8'(PGRM_PWE_FIRST + 1): next_pwe[23:16] = wr_byte;
            8'(PGRM_PWE_FIRST + 2): next_pwe[15:8]  = wr_byte;
            default:               next_pwe[7:0]   = wr_byte;
         endcase
      end
      next_tbl_loaded = 1'b1;
      next_upper_table_select = tbl_loaded ? upper_table_select : s_pon;
      if (tbl_loaded && dp_wr && dp_addr == PGRM_TBLSEL)
         next_upper_table_select = wr_byte;
      next_en_env = en_env;
      next_en_m34 = en_m34;
      next_en_fg  = en_fg;
      if (w_en) begin
         case (dp_addr)
            PGRM_EN_ENV: next_en_env = wr_byte;
            PGRM_EN_M34: next_en_m34 = wr_byte & PGRM_M34_MASK;
            default:     next_en_fg  = wr_byte & PGRM_FG_MASK;
         endcase
      end
      // shadowed bytes commit only while disable is clear; ee bytes always
      next_commit = mem_we | (w_en & ~s_shadow_write_disable);
      next_c_addr = dp_addr;
      // enables commit the stored value, reserved bits cleared
      next_c_data = (w_en && dp_addr == PGRM_EN_M34) ? (wr_byte & PGRM_M34_MASK)
                  : (w_en && dp_addr == PGRM_EN_FG)  ? (wr_byte & PGRM_FG_MASK) : wr_byte;
      next_c_tbl  = upper_table_select;
      next_warn_b = {s_warn, 4'h0};
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= 8'h00;
         rdata <= 32'h0000_0000;
         warn_b <= 8'h00;
         password_entry <= PGRM_PWE_RESET;
         upper_table_select <= 8'h00;
         tbl_loaded <= 1'b0;
         en_env <= PGRM_EN_RESET;
         en_m34 <= PGRM_EN_RESET;
         en_fg <= PGRM_EN_RESET;
         commit <= 1'b0;
         c_addr <= 8'h00;
         c_data <= 8'h00;
         c_tbl <= 8'h00;
      end else begin
         dp_wr <= next_dp_wr;
         dp_rd <= next_dp_rd;
         dp_addr <= next_dp_addr;
         rdata <= next_rdata;
         warn_b <= next_warn_b;
         password_entry <= next_pwe;
         upper_table_select <= next_upper_table_select;
         tbl_loaded <= next_tbl_loaded;
         en_env <= next_en_env;
         en_m34 <= next_en_m34;
         en_fg <= next_en_fg;
         commit <= next_commit;
         c_addr <= next_c_addr;
         c_data <= next_c_data;
         c_tbl <= next_c_tbl;
      end
   end

   // user memory image of the nonvolatile bytes
   genvar gi;
   generate
      for (gi = 0; gi < PGRM_USER_BYTES; gi++) begin : g_mem
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               user_mem[gi] <= 8'h00;
            else if (mem_we && mem_idx == 7'(gi))
               user_mem[gi] <= wr_byte;
         end
      end
   endgenerate

   // ************************************************************
   // outputs
   // ************************************************************
   assign hrdata    = rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign nv_commit       = commit;
   assign nv_commit_addr  = c_addr;
   assign nv_commit_data  = c_data;
   assign nv_commit_table = c_tbl;
   logic txf, fg;
   assign txf = |(s_env & en_env) | |(s_m34 & en_m34[7:4]);
   assign fg  = (s_fga[2] & en_fg[3]) | (s_fga[1] & en_fg[1]) | (s_fga[0] & en_fg[0]);
   assign transmit_fault_interrupt = txf;
   assign fault_gate_signal        = fg;

   // ************************************************************
   // checks
   // ************************************************************
   pwe_reads_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_ok && !hwrite && a_sel >= PGRM_PWE_FIRST && a_sel <= PGRM_PWE_LAST)
      |=> hrdata == 32'h0000_0000) else $error("password entry read not zero");
   rsvd_reads_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_ok && !hwrite && a_sel >= PGRM_RSV_LO && a_sel <= PGRM_RSV_HI)
      |=> hrdata == 32'h0000_0000) else $error("reserved read not zero");
   warn_follows_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> warn_b[7:4] == $past(s_warn) && warn_b[3:0] == 4'h0)
      else $error("warning byte mismatch");
   level_nest_a: assert property (@(posedge hclk) disable iff (!hresetn)
      higher_privilege_level |-> lower_privilege_level) else $error("levels not nested");
   m34_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      en_m34[3:0] == 4'h0) else $error("reserved enable bits set");
   txf_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
      transmit_fault_interrupt == (|(s_env & en_env) || |(s_m34 & en_m34[7:4])))
      else $error("interrupt mismatch");
   tbl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tbl_loaded && dp_wr && dp_addr == PGRM_TBLSEL) |=> upper_table_select == $past(hwdata[7:0]))
      else $error("table select not written");
   shadow_write_disable_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (w_en && s_shadow_write_disable) |=> !nv_commit) else $error("commit while disabled");
   pwe_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(tbl_loaded) |-> password_entry == PGRM_PWE_RESET) else $error("entry reset wrong");

   // ************************************************************
   // bus and access checks
   // ************************************************************
   // the bench gives up after 20 cycles without ready, so ready and okay must hold always
   bus_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("slave not ready or not okay");

   tbl_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(tbl_loaded) |-> upper_table_select == $past(s_pon))
      else $error("table select not loaded");

   en_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(tbl_loaded) |-> {en_env, en_m34, en_fg} == 24'h000000)
      else $error("enables not cleared");

   fg_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (en_fg & ~PGRM_FG_MASK) == 8'h00)
      else $error("reserved fault gate bits set");

   fg_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_fga == 3'b000 || en_fg == 8'h00) |-> !fault_gate_signal)
      else $error("fault gate without cause");

   txf_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (en_env == 8'h00 && en_m34 == 8'h00) |-> !transmit_fault_interrupt)
      else $error("interrupt without enable");

   env_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (w_en && dp_addr == PGRM_EN_ENV) |=> en_env == $past(hwdata[7:0]))
      else $error("env enable not written");

   m34_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (w_en && dp_addr == PGRM_EN_M34) |=> en_m34 == ($past(hwdata[7:0]) & PGRM_M34_MASK))
      else $error("mon34 enable not written");

   mem_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mem_we |=> user_mem[$past(mem_idx)] == $past(wr_byte))
      else $error("user byte not written");

   pwe_msb_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (dp_wr && dp_addr == PGRM_PWE_FIRST) |=> password_entry[31:24] == $past(hwdata[7:0]))
      else $error("entry top byte not written");

   lvl_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (password_entry == s_pw1) |-> lower_privilege_level)
      else $error("lower level not granted");

   shadow_write_disable_commit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (w_en && !s_shadow_write_disable) |=> nv_commit)
      else $error("enable write not committed");

   commit_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
      nv_commit |-> $past(dp_wr))
      else $error("commit without write");

   // denied enable reads must not leak the stored value
   rd_deny_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_ok && !hwrite && in_en && !lvl1) |=> hrdata == 32'h0000_0000)
      else $error("denied read not zero");

   tbl_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_ok && !hwrite && a_sel == PGRM_TBLSEL) |=> hrdata == {24'h000000, $past(upper_table_select)})
      else $error("table select read wrong");

   // read data stands one cycle only
   hrdata_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !dp_rd |-> hrdata == 32'h0000_0000)
      else $error("read data outside data phase");

   m34_rsvd_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_ok && !hwrite && a_sel == PGRM_WARN_B) |=> hrdata[3:0] == 4'h0)
      else $error("reserved status bits set");
endmodule : pgrm_top
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pgrm_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, lower_pw_value, higher_pw_value, rv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  mon34_warn, mon34_alarm;
   logic [7:0]  env_alarm, power_on_table_choice, nv_commit_addr, nv_commit_data, nv_commit_table;
   logic        bias_high_alarm, tx_power_high_alarm, tx_power_low_alarm, mask_in_table5;
   logic        shadow_write_disable, lower_privilege_level, higher_privilege_level, nv_commit;
   logic        transmit_fault_interrupt, fault_gate_signal;
   logic [5:0]  region_grants;
   logic [7:0]  a;
   int          errors, comparisons;
   localparam logic [31:0] PW_HI = 32'h5A3C_96E1;
   localparam logic [31:0] PW_NONE = 32'h0102_0304;

   always #5 hclk = ~hclk;

   pgrm_top pgrm_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mon34_warn(mon34_warn),
      .env_alarm(env_alarm), .mon34_alarm(mon34_alarm), .bias_high_alarm(bias_high_alarm),
      .tx_power_high_alarm(tx_power_high_alarm), .tx_power_low_alarm(tx_power_low_alarm),
      .lower_pw_value(lower_pw_value), .higher_pw_value(higher_pw_value),
      .power_on_table_choice(power_on_table_choice), .mask_in_table5(mask_in_table5),
      .shadow_write_disable(shadow_write_disable), .region_grants(region_grants),
      .lower_privilege_level(lower_privilege_level), .higher_privilege_level(higher_privilege_level),
      .nv_commit(nv_commit), .nv_commit_addr(nv_commit_addr), .nv_commit_data(nv_commit_data),
      .nv_commit_table(nv_commit_table), .transmit_fault_interrupt(transmit_fault_interrupt),
      .fault_gate_signal(fault_gate_signal));

   // ************************************************************
   // bus and checking tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   task automatic edge_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         errors++;
         give_verdict();
      end
   endtask : edge_rdy

   // byte offset goes out as word address, each phase waits up to 20 cycles for ready
   task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {22'h0, off, 2'b00};
      hwrite <= w;
      hsize  <= 3'b010;
      edge_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      edge_rdy();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      logic [31:0] dummy;
      bus(1'b1, off, {24'h0, d}, dummy);
   endtask : wr

   task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
      logic [31:0] r;
      bus(1'b0, off, 32'h0, r);
      check(r, {24'h0, exp});
   endtask : rd_chk

   task automatic settle(input logic [5:0] g);
      region_grants <= g;
      repeat (3) @(posedge hclk);
   endtask : settle

   task automatic pw(input logic [31:0] v);
      for (int i = 0; i < 4; i++) wr(PGRM_PWE_FIRST + 8'(i), v[31-8*i -: 8]);
      @(posedge hclk);
   endtask : pw

   task automatic commit(input logic on, input logic [7:0] ad, input logic [7:0] d,
                         input logic [7:0] t);
      logic seen;
      seen = 1'b0;
      repeat (4) begin
         @(posedge hclk);
         if (nv_commit === 1'b1 && !seen) begin
            seen = 1'b1;
            check({nv_commit_table, nv_commit_addr, nv_commit_data}, {8'h0, t, ad, d});
         end
      end
      check(seen, on);
   endtask : commit

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; haddr = 0; hwdata = 0; htrans = 0;
      hsize = 3'b010; mon34_warn = 0; mon34_alarm = 0; env_alarm = 0; bias_high_alarm = 0;
      tx_power_high_alarm = 0; tx_power_low_alarm = 0; mask_in_table5 = 0;
      shadow_write_disable = 0; region_grants = 0; errors = 0; comparisons = 0;
      lower_pw_value = 32'hFFFF_FFFF;
      higher_pw_value = PW_HI;
      power_on_table_choice = PGRM_TBL_ONE;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      // entry resets to all ones, so an all-ones lower password matches at once
      check({lower_privilege_level, higher_privilege_level}, 2'b10);
      rd_chk(PGRM_TBLSEL, PGRM_TBL_ONE);
      rd_chk(PGRM_PWE_FIRST, 8'h00);
      settle(6'h3F);
      for (int i = 0; i < 3; i++) rd_chk(PGRM_EN_ENV + 8'(i), PGRM_EN_RESET);
      rd_chk(PGRM_WARN_B, 8'h00);
      for (int i = 0; i < 4; i++) begin
         mon34_warn <= 4'b1000 >> i;
         settle(6'h3F);
         rd_chk(PGRM_WARN_B, {4'b1000 >> i, 4'h0});
      end
      mon34_warn <= 4'h0;
      for (int o = 8'h76; o <= 8'h7A; o++) begin
         wr(8'(o), 8'hFF);
         rd_chk(8'(o), 8'h00);
      end
      wr(PGRM_TBLSEL, 8'h5A);
      rd_chk(PGRM_TBLSEL, 8'h5A);
      wr(PGRM_TBLSEL, PGRM_TBL_ONE);
      $display("test reset_status_select done");
      pw(PW_NONE);
      check({lower_privilege_level, higher_privilege_level}, 2'b00);
      pw({PW_HI[7:0], PW_HI[31:8]});
      check({lower_privilege_level, higher_privilege_level}, 2'b00);
      pw(PW_HI);
      check({lower_privilege_level, higher_privilege_level}, 2'b11);
      rd_chk(PGRM_PWE_LAST, 8'h00);
      $display("test password done");
      // regions a, b, c at a boundary byte each
      for (int r = 0; r < 3; r++) begin
         a = (r == 0) ? PGRM_REGA_HI : (r == 1) ? PGRM_REGB_LO : PGRM_EN_ENV;
         pw(32'hFFFF_FFFF);
         settle(6'h00);
         wr(a, 8'h11);
         rd_chk(a, 8'h00);
         settle(6'b100000 >> (2 * r));
         wr(a, 8'h30 + 8'(r));
         commit(1'b1, a, 8'h30 + 8'(r), PGRM_TBL_ONE);
         rd_chk(a, 8'h30 + 8'(r));
         settle(6'b010000 >> (2 * r));
         wr(a, 8'h60);
         rd_chk(a, 8'h30 + 8'(r));
         settle(6'h00);
         rd_chk(a, 8'h00);
         pw(PW_HI);
         wr(a, 8'h90 + 8'(r));
         rd_chk(a, 8'h90 + 8'(r));
         pw(PW_NONE);
         rd_chk(a, 8'h00);
      end
      $display("test region_access done");
      pw(PW_HI);
      shadow_write_disable <= 1'b1;
      settle(6'h00);
      wr(PGRM_EN_M34, 8'hFF);
      commit(1'b0, PGRM_EN_M34, 8'hF0, PGRM_TBL_ONE);
      rd_chk(PGRM_EN_M34, PGRM_M34_MASK);
      shadow_write_disable <= 1'b0;
      settle(6'h00);
      wr(PGRM_EN_M34, 8'hF0);
      commit(1'b1, PGRM_EN_M34, 8'hF0, PGRM_TBL_ONE);
      mask_in_table5 <= 1'b1;
      settle(6'h00);
      rd_chk(PGRM_EN_M34, 8'h00);
      wr(PGRM_TBLSEL, PGRM_TBL_FIVE);
      rd_chk(PGRM_EN_M34, 8'hF0);
      wr(PGRM_EN_FG, 8'hFF);
      commit(1'b1, PGRM_EN_FG, PGRM_FG_MASK, PGRM_TBL_FIVE);
      rd_chk(PGRM_EN_FG, PGRM_FG_MASK);
      mask_in_table5 <= 1'b0;
      wr(PGRM_TBLSEL, PGRM_TBL_ONE);
      $display("test shadow_mask done");
      wr(PGRM_EN_ENV, 8'hA5);
      wr(PGRM_EN_M34, 8'h50);
      wr(PGRM_EN_FG, 8'h0A);
      for (int i = 0; i < 8; i++) begin
         env_alarm <= 8'h01 << i;
         settle(6'h00);
         check(transmit_fault_interrupt, 8'hA5 >> i & 8'h01);
      end
      env_alarm <= 8'h00;
      for (int i = 0; i < 4; i++) begin
         mon34_alarm <= 4'h1 << i;
         settle(6'h00);
         check(transmit_fault_interrupt, 4'h5 >> i & 4'h1);
      end
      mon34_alarm <= 4'h0;
      for (int k = 0; k < 3; k++) begin
         {bias_high_alarm, tx_power_high_alarm, tx_power_low_alarm} <= 3'b100 >> k;
         settle(6'h00);
         check(fault_gate_signal, k != 2);
      end
      $display("test alarm_gating done");
      power_on_table_choice <= 8'h03;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      check({lower_privilege_level, higher_privilege_level}, 2'b10);
      rd_chk(PGRM_TBLSEL, 8'h03);
      $display("test second_reset done");
      give_verdict();
   end
endmodule : tb
`default_nettype wire
